// ---- wdrsc_pkg.sv ----
// Constants, field layouts and carrier types for the watchdog readback and state control bank.
// Assumes a register access port driven by the device's SPI decoder, one clock, active-low reset.
// Overview of operation
// - Closed span field, 7 bits, code times fifty watchdog cycles, zero at code zero.
// - Open span field, 7 bits, codes 0 and 1 give fifty cycles, else code times fifty.
// - Closed span readback register is read-only, bit 7 zero, resets to 0x46.
// - Open span readback register is read-only, bit 7 zero, resets to 0x78.
// - State control updates apply only after value and complement registers are checked.
// - Bits 7..4 request monitor two, monitor one, step-up, second step-down; reset zero.
// - State code 1 active, 3 disabled, 7 locked, others reserved; resets zero.
// - Watchdog cycle is a 10 us or 100 us tick per the active selection bit.
package wdrsc_pkg;
    localparam logic [7:0] CLOSED_SPAN_OFS = 8'h09;
    localparam logic [7:0] OPEN_SPAN_OFS = 8'h0b;
    localparam logic [7:0] STATE_CTL_OFS = 8'h34;
    localparam logic [7:0] STATE_CMP_OFS = 8'h35;
    localparam logic [7:0] CLOSED_SPAN_RST = 8'h46;
    localparam logic [7:0] OPEN_SPAN_RST = 8'h78;
    localparam logic [7:0] STATE_CTL_RST = 8'h00;
    localparam logic [7:0] STATE_CMP_RST = 8'h00;
    localparam logic [6:0] SPAN_FIELD_MASK = 7'h7f;
    localparam logic [7:0] STATE_CTL_MASK = 8'hf7;
    localparam int SPAN_STEP_CYCLES = 50;
    localparam int TICK_SHORT_US = 10;
    localparam int TICK_LONG_US = 100;
    localparam int CLK_MHZ = 50;
    localparam int TICK_SHORT_CLKS = TICK_SHORT_US * CLK_MHZ;
    localparam int TICK_LONG_CLKS = TICK_LONG_US * CLK_MHZ;
    localparam logic [2:0] STATE_CODE_ACTIVE = 3'h1;
    localparam logic [2:0] STATE_CODE_DISABLED = 3'h3;
    localparam logic [2:0] STATE_CODE_LOCKED = 3'h7;

    // Register access request from the SPI decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdrsc_req_s;

    // Enable requests towards the rail controllers
    typedef struct packed {
        logic ext_monitor_two_req;
        logic ext_monitor_one_req;
        logic step_up_reg_req;
        logic second_step_down_req;
    } wdrsc_en_s;

    typedef enum logic [3:0] {
        ST_INIT = 4'b0001,
        ST_ACTIVE = 4'b0010,
        ST_DISABLED = 4'b0100,
        ST_LOCKED = 4'b1000
    } wdrsc_state_e;
endpackage : wdrsc_pkg

// ---- wdrsc_bank.sv ----
// Readback mirrors of the active watchdog spans and the protected device state control register.
// Assumes the SPI decoder presents one-cycle read/write strobes and that span sources are in clk domain.
module wdrsc_bank
    import wdrsc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire wdrsc_req_s req,
    input wire logic [6:0] closed_span_len,
    input wire logic [6:0] open_span_len,
    input wire logic tick_period_sel,
    output logic [7:0] rdata_ff,
    output logic rvalid_ff,
    output logic [15:0] closed_span_cycles_ff,
    output logic [15:0] open_span_cycles_ff,
    output logic [12:0] tick_clks_ff,
    output wdrsc_en_s en_req_ff,
    output logic [2:0] target_state_code_ff,
    output wdrsc_state_e dev_state_ff,
    output logic cmp_fail_ff
);

    // Open span code to cycles, codes 0 and 1 share fifty
    function automatic logic [15:0] open_cycles(input logic [6:0] code);
        logic [6:0] c;
        c = (code == 7'h00) ? 7'h01 : code;
        return 16'(c) * 16'(SPAN_STEP_CYCLES);
    endfunction : open_cycles

    logic [7:0] closed_mirror_ff, nxt_closed_mirror;
    logic [7:0] open_mirror_ff, nxt_open_mirror;
    logic [7:0] ctl_ff, nxt_ctl;
    logic [7:0] cmp_ff, nxt_cmp;
    logic [7:0] nxt_rdata;
    logic nxt_rvalid;
    logic [15:0] nxt_closed_cycles, nxt_open_cycles;
    logic [12:0] nxt_tick_clks;
    wdrsc_en_s nxt_en_req;
    logic [2:0] nxt_target;
    wdrsc_state_e nxt_state;
    logic nxt_cmp_fail;
    logic [7:0] staged;
    logic pair_ok;

    logic ctl_hit;
    logic cmp_hit;
    wdrsc_state_e decoded_state;

    // Write strobe aimed at one register offset
    function automatic logic wr_hit(input wdrsc_req_s r, input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction : wr_hit

    // Requested code to device state; reserved codes keep the current one
    function automatic wdrsc_state_e decode_state(input logic [2:0] code, input wdrsc_state_e cur);
        wdrsc_state_e s;
        unique case (code)
            STATE_CODE_ACTIVE: s = ST_ACTIVE;
            STATE_CODE_DISABLED: s = ST_DISABLED;
            STATE_CODE_LOCKED: s = ST_LOCKED;
            default: s = cur;
        endcase
        return s;
    endfunction : decode_state

    // Mirrors follow the active spans, host writes have no effect
    always_comb
    begin
        nxt_closed_mirror = {1'b0, closed_span_len & SPAN_FIELD_MASK};
        nxt_open_mirror = {1'b0, open_span_len & SPAN_FIELD_MASK};
    end

    // Mirror registers, reset to the default span codes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            closed_mirror_ff <= CLOSED_SPAN_RST;
            open_mirror_ff <= OPEN_SPAN_RST;
        end
        else
        begin
            closed_mirror_ff <= nxt_closed_mirror;
            open_mirror_ff <= nxt_open_mirror;
        end
    end

    // Span lengths in watchdog cycles, tick length in clocks
    always_comb
    begin
        nxt_closed_cycles = 16'(closed_mirror_ff[6:0]) * 16'(SPAN_STEP_CYCLES);
        nxt_open_cycles = open_cycles(open_mirror_ff[6:0]);
        nxt_tick_clks = tick_period_sel ? 13'(TICK_LONG_CLKS) : 13'(TICK_SHORT_CLKS);
    end

    // Derived length registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            closed_span_cycles_ff <= 16'h0000;
            open_span_cycles_ff <= 16'h0000;
            tick_clks_ff <= 13'h0000;
        end
        else
        begin
            closed_span_cycles_ff <= nxt_closed_cycles;
            open_span_cycles_ff <= nxt_open_cycles;
            tick_clks_ff <= nxt_tick_clks;
        end
    end

    // Value and complement registers take host writes, bit 3 stays zero
    always_comb
    begin
        ctl_hit = wr_hit(req, STATE_CTL_OFS);
        cmp_hit = wr_hit(req, STATE_CMP_OFS);
        nxt_ctl = ctl_hit ? (req.wdata & STATE_CTL_MASK) : ctl_ff;
        nxt_cmp = cmp_hit ? (req.wdata & STATE_CTL_MASK) : cmp_ff;
    end

    // Value and complement registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl_ff <= STATE_CTL_RST;
            cmp_ff <= STATE_CMP_RST;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
            cmp_ff <= nxt_cmp;
        end
    end

    // Pair check on the complement write; a pass applies the staged value
    always_comb
    begin
        nxt_en_req = en_req_ff;
        nxt_target = target_state_code_ff;
        nxt_cmp_fail = cmp_fail_ff;
        staged = ctl_ff;
        pair_ok = 1'b0;
        if (cmp_hit)
        begin
            pair_ok = ((staged ^ nxt_cmp) == STATE_CTL_MASK);
            nxt_cmp_fail = !pair_ok;
            if (pair_ok)
            begin
                nxt_en_req = wdrsc_en_s'(staged[7:4]);
                nxt_target = staged[2:0];
            end
        end
    end

    // Applied enables, state code and check result
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_req_ff <= wdrsc_en_s'(4'h0);
            target_state_code_ff <= 3'h0;
            cmp_fail_ff <= 1'b0;
        end
        else
        begin
            en_req_ff <= nxt_en_req;
            target_state_code_ff <= nxt_target;
            cmp_fail_ff <= nxt_cmp_fail;
        end
    end

    // Device state moves only on a validated, non-reserved code
    always_comb
    begin
        decoded_state = decode_state(staged[2:0], dev_state_ff);
        nxt_state = pair_ok ? decoded_state : dev_state_ff;
    end

    // Device state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dev_state_ff <= ST_INIT;
        end
        else
        begin
            dev_state_ff <= nxt_state;
        end
    end

    // Read data mux, unmapped reads give zero
    always_comb
    begin
        nxt_rvalid = req.rd;
        nxt_rdata = 8'h00;
        if (req.rd)
        begin
            unique case (req.addr)
                CLOSED_SPAN_OFS: nxt_rdata = closed_mirror_ff;
                OPEN_SPAN_OFS: nxt_rdata = open_mirror_ff;
                STATE_CTL_OFS: nxt_rdata = {en_req_ff, 1'b0, target_state_code_ff};
                STATE_CMP_OFS: nxt_rdata = cmp_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // Read answer registers, one cycle per read strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

endmodule : wdrsc_bank

// ---- wdrsc_host.sv ----
// Host model: issues register strobes to the bank as the serial master would.
// Assumes each call starts in the time step of a rising clock edge.
module wdrsc_host
    import wdrsc_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata_ff,
    output wdrsc_req_s req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // One access; read data taken at the edge after the strobe is taken
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        req <= '{w, !w, a, d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        q = rdata_ff;
    endtask : acc
    // Value then complement on back-to-back edges; bad spoils the complement
    task automatic pair(input logic [7:0] v, input logic bad);
        req <= '{1'b1, 1'b0, STATE_CTL_OFS, v};
        @(posedge clk);
        req <= '{1'b1, 1'b0, STATE_CMP_OFS, v ^ (bad ? 8'h07 : 8'hf7)};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : pair
endmodule : wdrsc_host

// ---- wdrsc_bank_sva.sv ----
// Port checker for the bank; bound from the bench top.
// Assumes span inputs are held for three cycles before derived values are judged.
module wdrsc_bank_sva
    import wdrsc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire wdrsc_req_s req,
    input wire logic [6:0] closed_span_len,
    input wire logic [6:0] open_span_len,
    input wire logic tick_period_sel,
    input wire logic [7:0] rdata_ff,
    input wire logic rvalid_ff,
    input wire logic [15:0] closed_span_cycles_ff,
    input wire logic [15:0] open_span_cycles_ff,
    input wire logic [12:0] tick_clks_ff,
    input wire wdrsc_en_s en_req_ff,
    input wire logic [2:0] target_state_code_ff,
    input wire wdrsc_state_e dev_state_ff,
    input wire logic cmp_fail_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Value write then complement write, ok says whether they match
    sequence pair_s(ok);
        req.wr && req.addr == STATE_CTL_OFS ##1 req.wr && req.addr == STATE_CMP_OFS &&
            ((((req.wdata ^ $past(req.wdata)) & STATE_CTL_MASK) == STATE_CTL_MASK) == ok);
    endsequence
    // Expected state after a validated code
    function automatic wdrsc_state_e dec(logic [2:0] c, wdrsc_state_e s);
        return c == 3'h1 ? ST_ACTIVE : c == 3'h3 ? ST_DISABLED : c == 3'h7 ? ST_LOCKED : s;
    endfunction : dec
    cl_span_a: assert property ((nrst && $stable(closed_span_len))[*3] |-> closed_span_cycles_ff == 16'(closed_span_len) * 16'd50) else $error("closed span cycles wrong");
    op_span_a: assert property ((nrst && $stable(open_span_len))[*3] |-> open_span_cycles_ff == (open_span_len == 7'h00 ? 16'd50 : 16'(open_span_len) * 16'd50)) else $error("open span cycles wrong");
    tick_len_a: assert property ((nrst && $stable(tick_period_sel))[*3] |-> tick_clks_ff == (tick_period_sel ? 13'd5000 : 13'd500)) else $error("tick length wrong");
    ro_read_a: assert property (req.rd && req.addr == CLOSED_SPAN_OFS && $past(nrst, 2) && $stable(closed_span_len) |=> rvalid_ff && rdata_ff == {1'b0, $past(closed_span_len)}) else $error("closed readback wrong");
    ctl_hold_a: assert property (req.wr && req.addr == STATE_CTL_OFS && !$past(req.wr) |=> $stable(en_req_ff) && $stable(dev_state_ff)) else $error("value write alone applied");
    pair_ok_a: assert property (pair_s(1'b1) |=> en_req_ff == $past(req.wdata[7:4], 2) && target_state_code_ff == $past(req.wdata[2:0], 2) && !cmp_fail_ff) else $error("valid pair not applied");
    pair_bad_a: assert property (pair_s(1'b0) |=> cmp_fail_ff && $stable(en_req_ff) && $stable(target_state_code_ff)) else $error("bad pair applied");
    state_dec_a: assert property (pair_s(1'b1) |=> dev_state_ff == dec($past(req.wdata[2:0], 2), $past(dev_state_ff))) else $error("state decode wrong");
    rst_val_a: assert property ($rose(nrst) |-> en_req_ff == 4'h0 && target_state_code_ff == 3'h0 && dev_state_ff == ST_INIT) else $error("reset values wrong");
endmodule : wdrsc_bank_sva

// ---- wdrsc_bank_tb_top.sv ----
// Bench top: bank, host model, checker bind and directed scenarios.
// Assumes the host model starts every access at a rising edge.
module wdrsc_bank_tb_top
    import wdrsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [6:0] closed_span_len = 7'h46;
    logic [6:0] open_span_len = 7'h78;
    logic tick_period_sel = 1'b1;
    wdrsc_req_s req;
    logic [7:0] rdata_ff;
    logic rvalid_ff, cmp_fail_ff;
    logic [15:0] closed_span_cycles_ff, open_span_cycles_ff;
    logic [12:0] tick_clks_ff;
    wdrsc_en_s en_req_ff;
    logic [2:0] target_state_code_ff;
    wdrsc_state_e dev_state_ff;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    wdrsc_bank u_wdrsc_bank (.clk, .nrst, .req, .closed_span_len, .open_span_len, .tick_period_sel, .rdata_ff,
        .rvalid_ff, .closed_span_cycles_ff, .open_span_cycles_ff, .tick_clks_ff, .en_req_ff, .target_state_code_ff,
        .dev_state_ff, .cmp_fail_ff);
    wdrsc_host u_wdrsc_host (.clk, .rdata_ff, .req);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // Read-only mirrors ignore writes; unmapped place reads zero
    task automatic t_readback();
        logic [7:0] q;
        u_wdrsc_host.acc(1'b1, CLOSED_SPAN_OFS, 8'hff, q);
        u_wdrsc_host.acc(1'b0, CLOSED_SPAN_OFS, 8'h00, q);
        chk(16'(q), 16'h0046);
        u_wdrsc_host.acc(1'b1, OPEN_SPAN_OFS, 8'h80, q);
        u_wdrsc_host.acc(1'b0, OPEN_SPAN_OFS, 8'h00, q);
        chk(16'(q), 16'h0078);
        u_wdrsc_host.acc(1'b0, 8'h20, 8'h00, q);
        chk(16'(q), 16'h0000);
    endtask : t_readback
    // Span and tick conversions at the field boundaries
    task automatic t_spans(input logic [6:0] c, input logic [6:0] o, input logic t, input logic [15:0] ec,
        input logic [15:0] eo, input logic [15:0] et);
        closed_span_len <= c;
        open_span_len <= o;
        tick_period_sel <= t;
        repeat (4) @(posedge clk);
        chk(closed_span_cycles_ff, ec);
        chk(open_span_cycles_ff, eo);
        chk(16'(tick_clks_ff), et);
    endtask : t_spans
    // Every state code, a reserved one, then a spoiled complement
    task automatic t_pairs();
        logic [7:0] v [4] = '{8'h81, 8'h43, 8'h27, 8'hf2};
        wdrsc_state_e st [4] = '{ST_ACTIVE, ST_DISABLED, ST_LOCKED, ST_LOCKED};
        logic [7:0] q;
        for (int i = 0; i < 4; i++)
        begin
            u_wdrsc_host.pair(v[i], 1'b0);
            chk(16'(en_req_ff), 16'(v[i][7:4]));
            chk(16'(target_state_code_ff), 16'(v[i][2:0]));
            chk(16'(dev_state_ff), 16'(st[i]));
            chk(16'(cmp_fail_ff), 16'h0000);
        end
        u_wdrsc_host.pair(8'h11, 1'b1);
        chk(16'(cmp_fail_ff), 16'h0001);
        chk(16'(en_req_ff), 16'h000f);
        u_wdrsc_host.acc(1'b0, STATE_CTL_OFS, 8'h00, q);
        chk(16'(q), 16'h00f2);
    endtask : t_pairs
    // Mid-run reset returns the applied state to its defaults
    task automatic t_reset();
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(16'(en_req_ff), 16'h0000);
        chk(16'(target_state_code_ff), 16'h0000);
        chk(16'(dev_state_ff), 16'(ST_INIT));
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : t_reset
    // Free-running clock and cycle ceiling
    initial forever #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            test_done();
        end
    end
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_readback();
        t_spans(7'h7f, 7'h00, 1'b0, 16'd6350, 16'd50, 16'd500);
        t_spans(7'h00, 7'h01, 1'b1, 16'd0, 16'd50, 16'd5000);
        t_pairs();
        t_reset();
        test_done();
    end
endmodule : wdrsc_bank_tb_top
bind wdrsc_bank wdrsc_bank_sva u_wdrsc_bank_sva (.clk, .nrst, .req, .closed_span_len, .open_span_len,
    .tick_period_sel, .rdata_ff, .rvalid_ff, .closed_span_cycles_ff, .open_span_cycles_ff, .tick_clks_ff,
    .en_req_ff, .target_state_code_ff, .dev_state_ff, .cmp_fail_ff);
